/* File: verilog/lgc_pkg.sv */
// Package of constants for the Gold code generator.
// Assumes one clock domain at 100 MHz and a synchronous active-low reset.
package lgc_pkg;
    localparam int SEG_LEN     = 16;
    localparam int SEG_AW      = 4;
    localparam int LEN_A       = 52;
    localparam int TAP_A_LO    = 49;
    localparam int TAP_A_HI    = 52;
    localparam int LEN_B       = 52;
    localparam int TAP_B_LO    = 49;
    localparam int TAP_B_HI    = 52;
    localparam int FIFO_DEPTH  = 4;
    localparam int FIFO_WIDTH  = 1;
    localparam logic [51:0] FILL_A_RST = 52'h0000000000001;
    localparam logic [51:0] FILL_B_RST = 52'h8000000000001;
endpackage

/* File: verilog/lgc_fifo.sv */
// Small synchronous FIFO for the code chip stream.
// Assumes the clock and reset of the generator.
`timescale 1ns/1ps
module lgc_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
            $error("lgc_fifo: DEPTH must be a power of two >= 2");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [WIDTH-1:0] dout_q;
    logic             dval_q;
    wire              push;
    wire              pop;
    wire              load;
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign push      = in_valid && in_ready;
    assign load      = (cnt_q != '0) && (!dval_q || out_ready);
    assign pop       = load;
    assign out_valid = dval_q;
    assign out_data  = dout_q;
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_q   <= '0;
            rd_q   <= '0;
            cnt_q  <= '0;
            dout_q <= '0;
            dval_q <= 1'b0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
            if (load) begin
                dout_q <= mem_q[rd_q];
                dval_q <= 1'b1;
            end else if (out_ready) begin
                dval_q <= 1'b0;
            end
        end
    end
endmodule // lgc_fifo

/* File: verilog/lgc_gold_gen.sv */
// Gold code generator made of two maximal-length feedback registers.
// Assumes synchronous inputs on clk and a consumer that takes one chip per
// cycle through a valid and ready handshake.
`timescale 1ns/1ps

// ****************************************************************
// Function
// ****************************************************************
module lgc_gold_gen #(
    parameter int          LEN     = lgc_pkg::LEN_A,
    parameter int          TAP_LO  = lgc_pkg::TAP_A_LO,
    parameter int          DEPTH   = lgc_pkg::FIFO_DEPTH
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          chip_en,
    input  wire logic          prime,
    input  wire logic [LEN-1:0] fill_a,
    input  wire logic [LEN-1:0] fill_b,
    output logic               primed,
    output logic               chip_valid,
    input  wire logic          chip_ready,
    output logic               chip
);
    localparam int SLEN      = lgc_pkg::SEG_LEN;
    localparam int NSEG      = LEN / SLEN;
    localparam int NEXT      = LEN - NSEG * SLEN;
    localparam int SEG_SEL_W = lgc_pkg::SEG_AW;
    localparam int TAP_SEG   = (TAP_LO - 1) / SLEN;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The fill ports and the reset fills are at most 52 stages wide.
    initial begin
        if (LEN < 2 || LEN > 52)
            $error("lgc_gold_gen: unsupported length");
        if (NSEG < 1)
            $error("lgc_gold_gen: need one full segment");
        if (TAP_LO < 1 || TAP_LO >= LEN)
            $error("lgc_gold_gen: unsupported tap");
        if (TAP_LO > NSEG * SLEN && TAP_LO < LEN - NEXT + 1)
            $error("lgc_gold_gen: tap not reachable");
        if (DEPTH < 2)
            $error("lgc_gold_gen: buffer too shallow");
        if ((1 << SEG_SEL_W) != SLEN)
            $error("lgc_gold_gen: segment address width mismatch");
        if (lgc_pkg::FIFO_WIDTH != 1)
            $error("lgc_gold_gen: buffer must carry one chip per word");
    end

    // ****************************************************************
    // Register chains
    // ****************************************************************
    // Stage k of a chain is bit k-1; bit 0 takes the serial input.
    // Register B runs with the same taps as A but with its own fill.
    logic [LEN-1:0] reg_a_q;
    logic [LEN-1:0] reg_b_q;
    logic [LEN-1:0] reg_a_d;
    logic [LEN-1:0] reg_b_d;
    logic           primed_q;
    wire            fifo_ready;
    wire            step;
    wire            fb_a;
    wire            fb_b;
    wire            tap_a;
    wire            tap_b;
    wire            lock_a;
    wire            lock_b;
    wire [LEN-1:0]  safe_a;
    wire [LEN-1:0]  safe_b;
    wire [LEN-1:0]  shift_a;
    wire [LEN-1:0]  shift_b;
    wire [SEG_SEL_W-1:0] tap_addr;

    // Each 16-stage segment exposes an addressed stage and its cascade end.
    wire [NSEG-1:0] seg_sel_a;
    wire [NSEG-1:0] seg_sel_b;
    wire [NSEG-1:0] segment_cascade_out_a;
    wire [NSEG-1:0] segment_cascade_out_b;
    assign tap_addr = SEG_SEL_W'((TAP_LO - 1) % SLEN);
    genvar g;
    generate
        for (g = 0; g < NSEG; g++) begin : g_seg
            wire [SLEN-1:0] seg_a;
            wire [SLEN-1:0] seg_b;
            wire            seg_in_a;
            wire            seg_in_b;
            assign seg_a = reg_a_q[g*SLEN +: SLEN];
            assign seg_b = reg_b_q[g*SLEN +: SLEN];
            assign seg_sel_a[g] = seg_a[tap_addr];
            assign seg_sel_b[g] = seg_b[tap_addr];
            assign segment_cascade_out_a[g] = seg_a[SLEN-1];
            assign segment_cascade_out_b[g] = seg_b[SLEN-1];
            // The first segment takes feedback, the others the cascade.
            if (g == 0) begin : g_head
                assign seg_in_a = fb_a;
                assign seg_in_b = fb_b;
            end else begin : g_link
                assign seg_in_a = segment_cascade_out_a[g-1];
                assign seg_in_b = segment_cascade_out_b[g-1];
            end
            assign shift_a[g*SLEN +: SLEN] = {seg_a[SLEN-2:0], seg_in_a};
            assign shift_b[g*SLEN +: SLEN] = {seg_b[SLEN-2:0], seg_in_b};
        end
    endgenerate

    // ****************************************************************
    // Discrete extension stages
    // ****************************************************************
    // Stages beyond the last full segment are plain flip-flops fed by
    // the last cascade end, so taps there are read directly.
    generate
        if (NEXT > 1) begin : g_ext
            assign shift_a[LEN-1:LEN-NEXT] =
                {reg_a_q[LEN-2:LEN-NEXT], segment_cascade_out_a[NSEG-1]};
            assign shift_b[LEN-1:LEN-NEXT] =
                {reg_b_q[LEN-2:LEN-NEXT], segment_cascade_out_b[NSEG-1]};
        end else if (NEXT == 1) begin : g_ext1
            // A single extension stage takes the cascade end alone.
            assign shift_a[LEN-1] = segment_cascade_out_a[NSEG-1];
            assign shift_b[LEN-1] = segment_cascade_out_b[NSEG-1];
        end
    endgenerate

    // ****************************************************************
    // Tap selection
    // ****************************************************************
    // Taps past the last full segment sit in the discrete extension stages.
    generate
        if (TAP_SEG < NSEG) begin : g_tap_seg
            assign tap_a = seg_sel_a[TAP_SEG];
            assign tap_b = seg_sel_b[TAP_SEG];
        end else begin : g_tap_ext
            assign tap_a = reg_a_q[TAP_LO-1];
            assign tap_b = reg_b_q[TAP_LO-1];
        end
    endgenerate

    // ****************************************************************
    // Feedback and fill
    // ****************************************************************
    // XNOR feedback makes all-ones the single lock-up state.
    assign fb_a = ~(tap_a ^ reg_a_q[LEN-1]);
    assign fb_b = ~(tap_b ^ reg_b_q[LEN-1]);

    // A fill of all ones is replaced so the chain cannot stall.
    assign lock_a = &fill_a;
    assign lock_b = &fill_b;
    assign safe_a = lock_a ? {fill_a[LEN-1:1], 1'b0} : fill_a;
    assign safe_b = lock_b ? {fill_b[LEN-1:1], 1'b0} : fill_b;

    // ****************************************************************
    // Step control
    // ****************************************************************
    // The stream stalls when the buffer is full.
    // Prime wins over step so a reload never mixes with a shift.
    assign step = primed_q && chip_en && fifo_ready && !prime;

    // ****************************************************************
    // Register update
    // ****************************************************************
    // Stage contents change only by a whole fill or a one-stage shift.
    always_comb begin
        reg_a_d = reg_a_q;
        reg_b_d = reg_b_q;
        if (prime) begin
            reg_a_d = safe_a;
            reg_b_d = safe_b;
        end else if (step) begin
            reg_a_d = shift_a;
            reg_b_d = shift_b;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_a_q  <= lgc_pkg::FILL_A_RST[LEN-1:0];
            reg_b_q  <= lgc_pkg::FILL_B_RST[LEN-1:0];
            primed_q <= 1'b0;
        end else begin
            reg_a_q  <= reg_a_d;
            reg_b_q  <= reg_b_d;
            primed_q <= primed_q | prime;
        end
    end

    // ****************************************************************
    // Chip output
    // ****************************************************************
    // Both serial ends are read on one edge, so the pair stays aligned.
    wire gold_bit;
    assign gold_bit = reg_a_q[LEN-1] ^ reg_b_q[LEN-1];
    // The primed flag stays set until the next reset.
    assign primed   = primed_q;

    // The buffer absorbs consumer stalls; the chains hold while it is full.
    lgc_fifo #(
        .WIDTH (lgc_pkg::FIFO_WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (step),
        .in_ready  (fifo_ready),
        .in_data   (gold_bit),
        .out_valid (chip_valid),
        .out_ready (chip_ready),
        .out_data  (chip)
    );
endmodule // lgc_gold_gen

/* File: testbench/lgc_gold_sva.sv */
// Port assertions for the Gold code generator.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module lgc_gold_sva #(
    parameter int LEN = 52
) (
    input wire logic           clk,
    input wire logic           rst_b,
    input wire logic           chip_en,
    input wire logic           prime,
    input wire logic [LEN-1:0] fill_a,
    input wire logic [LEN-1:0] fill_b,
    input wire logic           primed,
    input wire logic           chip_valid,
    input wire logic           chip_ready,
    input wire logic           chip
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic stp = primed && chip_en && chip_ready && !prime;
    AST_RST: assert property (disable iff (1'b0) !rst_b |=>
        !primed && !chip_valid && !chip) else $error("reset");
    AST_PRIME: assert property (prime |=> primed) else $error("prime");
    AST_KEEP: assert property (primed |=> primed) else $error("keep");
    AST_IDLE: assert property (!primed |-> !chip_valid)
        else $error("idle");
    AST_PHOLD: assert property (!primed ##1 prime[*3] |-> !chip_valid)
        else $error("phold");
    AST_FIRST: assert property ($fell(prime) && primed && chip_en
        |-> ##[1:3] chip_valid) else $error("first");
    AST_HOLD: assert property (chip_valid && !chip_ready |=>
        chip_valid && $stable(chip)) else $error("hold");
    AST_RATE: assert property (stp[*4] |-> chip_valid)
        else $error("rate");
    cover property (prime);
    cover property (chip_valid && !chip_ready);
    cover property (chip_valid && chip_ready);
endmodule // lgc_gold_sva
bind lgc_gold_gen lgc_gold_sva #(.LEN(LEN)) u_sva (.clk(clk), .rst_b(rst_b),
    .chip_en(chip_en), .prime(prime), .fill_a(fill_a), .fill_b(fill_b),
    .primed(primed), .chip_valid(chip_valid), .chip_ready(chip_ready),
    .chip(chip));

/* File: testbench/lgc_chip_sink.sv */
// Consumer model that takes chips and keeps them in arrival order.
// Assumes the bench stalls it through stall at the falling edge.
`timescale 1ns/1ps
module lgc_chip_sink (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic stall,
    input  wire logic chip_valid,
    input  wire logic chip,
    output logic      chip_ready
);
    logic got[$];
    initial chip_ready = 1'b0;
    always @(negedge clk) chip_ready <= !stall;
    always @(posedge clk)
        if (rst_b && chip_valid && chip_ready) got.push_back(chip);
endmodule // lgc_chip_sink

/* File: testbench/test_lgc_gold_gen.sv */
// Self-checking bench for the Gold code generator.
// Assumes the consumer model and the checker are compiled beforehand.
`timescale 1ns/1ps
module test_lgc_gold_gen;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        chip_en = 1'b0;
    logic        prime = 1'b0;
    logic        stall = 1'b0;
    logic [51:0] fill_a = 52'h0;
    logic [51:0] fill_b = 52'h0;
    logic        primed, chip_valid, chip_ready, chip;
    logic [51:0] a_q, b_q;
    int          fail_count = 0;
    int          checks_done = 0;
    always #5 clk = ~clk;
    lgc_gold_gen DUT (.clk(clk), .rst_b(rst_b), .chip_en(chip_en),
        .prime(prime), .fill_a(fill_a), .fill_b(fill_b), .primed(primed),
        .chip_valid(chip_valid), .chip_ready(chip_ready), .chip(chip));
    lgc_chip_sink SNK (.clk(clk), .rst_b(rst_b), .stall(stall),
        .chip_valid(chip_valid), .chip(chip), .chip_ready(chip_ready));
    task automatic check(string w, logic s, logic e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %b seen %b", w, e, s);
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [51:0] adv(logic [51:0] s);
        return {s[50:0], ~(s[48] ^ s[51])};
    endfunction
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    // Primes, streams with a stall and a pause, then drains and compares.
    task automatic t_stream(logic [51:0] fa, logic [51:0] fb);
        SNK.got.delete();
        fill_a = fa;
        fill_b = fb;
        prime = 1'b1;
        cyc(3);
        prime = 1'b0;
        check("primed", primed, 1'b1);
        chip_en = 1'b1;
        cyc(40);
        stall = 1'b1;
        cyc(12);
        stall = 1'b0;
        chip_en = 1'b0;
        cyc(6);
        chip_en = 1'b1;
        cyc(30);
        chip_en = 1'b0;
        cyc(12);
        a_q = &fa ? {fa[51:1], 1'b0} : fa;
        b_q = &fb ? {fb[51:1], 1'b0} : fb;
        check("count", SNK.got.size() >= 70, 1'b1);
        foreach (SNK.got[i]) begin
            check("chip", SNK.got[i], a_q[51] ^ b_q[51]);
            a_q = adv(a_q);
            b_q = adv(b_q);
        end
    endtask
    initial begin
        cyc(20);
        rst_b = 1'b1;
        check("primed", primed, 1'b0);
        check("chip_valid", chip_valid, 1'b0);
        t_stream(52'h0123456789ABC, 52'h8000000000001);
        t_stream(52'hFFFFFFFFFFFFF, 52'h5A5A5A5A5A5A5);
        tally_and_finish();
    end
    initial begin
        #50000;
        fail_count++;
        tally_and_finish();
    end
endmodule // test_lgc_gold_gen
